// ===== src/mrcs_consts.svh
/*
 Offsets, field positions, reset values and decode constants of the
 midrange and high peripheral chip-select block.
 Assumes it is included by bare name after the package.
*/
`ifndef MRCS_CONSTS_SVH
`define MRCS_CONSTS_SVH

// ------------------------------------------------------------
// Register offsets (printed offsets, 8-bit register address)
// ------------------------------------------------------------
`define MRCS_OFS_MID_BASE   8'ha6
`define MRCS_OFS_AUX_CFG    8'ha8

// ------------------------------------------------------------
// Midrange base register fields
// ------------------------------------------------------------
`define MRCS_MB_BASE_HI     15
`define MRCS_MB_BASE_LO     9
`define MRCS_MB_RDY_BIT     2
`define MRCS_MB_WS_HI       1
`define MRCS_MB_WS_LO       0
`define MRCS_MB_ONES        16'h01f8

// ------------------------------------------------------------
// Auxiliary register fields
// ------------------------------------------------------------
`define MRCS_AX_SIZE_HI     14
`define MRCS_AX_SIZE_LO     8
`define MRCS_AX_SEL_BIT     7
`define MRCS_AX_SPACE_BIT   6
`define MRCS_AX_RDY_BIT     2
`define MRCS_AX_WS_HI       1
`define MRCS_AX_WS_LO       0
`define MRCS_AX_ONES        16'h8038

// ------------------------------------------------------------
// Reset values and decode constants
// ------------------------------------------------------------
`define MRCS_RST_BASE       7'h00
`define MRCS_RST_SIZE       7'h00
`define MRCS_RST_WS         2'h0
`define MRCS_HP5_SLOT       3'h5
`define MRCS_HP6_SLOT       3'h6
`define MRCS_RD_UNMAPPED    16'h0000

`endif

// ===== src/mrcs_decode.sv
/*
 Combinational address decode for the midrange block and the two high
 peripheral selects.
 Assumes address and cycle type are stable while cyc_start is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mrcs_consts.svh"

module mrcs_decode
	import mrcs_pkg::*;
(
	// Bus cycle
	input  wire logic [19:0] addr,
	input  wire logic        cyc_mem,
	// Midrange setup
	input  wire logic        mid_en,
	input  wire logic [6:0]  mid_base,
	input  wire logic [6:0]  mid_size,
	// High peripheral setup
	input  wire logic        hp_en,
	input  wire logic [8:0]  hp_base,
	input  wire logic        hp_space_mem,
	// Results
	output logic             mid_hit,
	output logic [1:0]       mid_idx,
	output logic [1:0]       hp_hit
);
	wire [6:0] free_mask;
	wire [6:0] base_diff;
	wire [6:0] idx_lo_bits;
	wire [6:0] idx_hi_bits;
	wire       size_ok;
	wire       space_ok;
	wire       hp_base_ok;

	// Block spans the bits below the one-hot size bit
	assign free_mask = mid_size - 7'h01;
	assign base_diff = (addr[19:13] ^ mid_base) & ~free_mask;
	assign size_ok   = (mid_size != 7'h00) && ((mid_size & free_mask) == 7'h00);

	// Select index sits just above the quarter size, 2K << k
	genvar k;
	generate
		for (k = 0; k < 7; k = k + 1) begin : g_idx
			assign idx_lo_bits[k] = mid_size[k] & addr[11 + k];
			assign idx_hi_bits[k] = mid_size[k] & addr[12 + k];
		end
	endgenerate

	// Memory cycles only, so an I/O-mapped peripheral range may overlap the block
	assign mid_hit    = mid_en && cyc_mem && size_ok && (base_diff == 7'h00);
	assign mid_idx    = {|idx_hi_bits, |idx_lo_bits};

	assign space_ok   = (cyc_mem == hp_space_mem);
	assign hp_base_ok = hp_en && space_ok && (addr[19:11] == hp_base);
	assign hp_hit[0]  = hp_base_ok && (addr[10:8] == `MRCS_HP5_SLOT);
	assign hp_hit[1]  = hp_base_ok && (addr[10:8] == `MRCS_HP6_SLOT);
endmodule

`default_nettype wire

// ===== src/mrcs_pkg.sv
/*
 Types shared by the chip-select block.
 Assumes nothing of its surroundings.
*/
package mrcs_pkg;
	typedef enum logic [1:0] {
		MRCS_WS_IDLE,
		MRCS_WS_COUNT
	} mrcs_ws_state_t;

	typedef enum logic [1:0] {
		MRCS_HP_OFF,
		MRCS_HP_CS,
		MRCS_HP_ADDR
	} mrcs_hp_mode_t;
endpackage

// ===== src/mrcs_top.sv
/*
 Midrange memory and high peripheral chip-select unit: two setup
 registers on a plain register port, address decode, select outputs
 and wait-state sequencing for each external bus cycle.
 Assumes the bus unit pulses cyc_start at the address phase of each
 cycle, holds cyc_addr and cyc_mem there, and starts no new cycle
 before cyc_done. The low peripheral unit supplies its base bits and
 a flag telling that its base register has been written.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mrcs_consts.svh"

// What this block does
// - High peripheral pins are either chip selects or latched a2/a1, chosen by one bit.
// - High peripheral pins stay high and idle after reset until configured.
// - In address mode any auxiliary register access alone activates the pins.
// - One-hot seven-bit size picks 8K to 512K block, split in four selects.
// - Peripheral selects answer memory cycles if space bit set, else I/O cycles.
// - High peripheral ready: ignore external ready when bit set, else wait for it.
// - High peripheral cycles get zero to three wait states from two-bit field.
// - Midrange selects idle until both midrange base and auxiliary registers written.
// - Midrange selects assert with muxed bus timing, one step after address phase.
// - Seven base bits compare to a19..a13; lower thirteen base bits are zero.
// - Midrange block decode does not check upper, lower or memory-mapped peripheral areas.
// - Midrange ready: ignore external ready when bit set, else wait for it.
// - Midrange cycles get zero to three wait states from two-bit field.
// - Midrange block may sit at any multiple of its own size in the one-megabyte memory space.
module mrcs_top
	import mrcs_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// Bus cycle from the bus unit
	input  wire logic        cyc_start,
	input  wire logic [19:0] cyc_addr,
	input  wire logic        cyc_mem,
	input  wire logic        ext_ready,
	output logic             cyc_done,
	// Low peripheral unit setup
	input  wire logic [8:0]  periph_base_bits,
	input  wire logic        periph_base_written,
	// Select pins, active low
	output logic      [3:0]  midrange_selects_n,
	output logic      [1:0]  high_peripheral_selects_n
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [6:0]  mid_base_reg;
	logic        mid_rdy_reg;
	logic [1:0]  mid_ws_reg;
	logic [6:0]  mid_size_reg;
	logic        sel_vs_addr_reg;
	logic        space_mem_reg;
	logic        hp_rdy_reg;
	logic [1:0]  hp_ws_reg;
	logic        mid_written_reg;
	logic        aux_written_reg;
	logic        aux_touched_reg;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	wire hit_mid_base = (reg_addr == `MRCS_OFS_MID_BASE);
	wire hit_aux      = (reg_addr == `MRCS_OFS_AUX_CFG);
	wire wr_mid_base  = reg_wr && hit_mid_base;
	wire wr_aux       = reg_wr && hit_aux;
	wire touch_aux    = (reg_wr || reg_rd) && hit_aux;

	// Reserved positions read back as the ones software must write
	wire [15:0] rd_mid_base = `MRCS_MB_ONES
		| {mid_base_reg, 6'h00, mid_rdy_reg, mid_ws_reg};
	wire [15:0] rd_aux = `MRCS_AX_ONES
		| {1'b0, mid_size_reg, sel_vs_addr_reg, space_mem_reg, 3'h0, hp_rdy_reg, hp_ws_reg};

	assign rdata_next = !reg_rd      ? rdata_reg :
	                    hit_mid_base ? rd_mid_base :
	                    hit_aux      ? rd_aux :
	                                   `MRCS_RD_UNMAPPED;
	assign reg_rdata = rdata_reg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mid_base_reg <= `MRCS_RST_BASE;
			mid_rdy_reg  <= 1'b0;
			mid_ws_reg   <= `MRCS_RST_WS;
		end else if (wr_mid_base) begin
			mid_base_reg <= reg_wdata[`MRCS_MB_BASE_HI:`MRCS_MB_BASE_LO];
			mid_rdy_reg  <= reg_wdata[`MRCS_MB_RDY_BIT];
			mid_ws_reg   <= reg_wdata[`MRCS_MB_WS_HI:`MRCS_MB_WS_LO];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mid_size_reg    <= `MRCS_RST_SIZE;
			sel_vs_addr_reg <= 1'b1;
			space_mem_reg   <= 1'b1;
			hp_rdy_reg      <= 1'b0;
			hp_ws_reg       <= `MRCS_RST_WS;
		end else if (wr_aux) begin
			mid_size_reg    <= reg_wdata[`MRCS_AX_SIZE_HI:`MRCS_AX_SIZE_LO];
			sel_vs_addr_reg <= reg_wdata[`MRCS_AX_SEL_BIT];
			space_mem_reg   <= reg_wdata[`MRCS_AX_SPACE_BIT];
			hp_rdy_reg      <= reg_wdata[`MRCS_AX_RDY_BIT];
			hp_ws_reg       <= reg_wdata[`MRCS_AX_WS_HI:`MRCS_AX_WS_LO];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mid_written_reg <= 1'b0;
			aux_written_reg <= 1'b0;
			aux_touched_reg <= 1'b0;
			rdata_reg       <= 16'h0000;
		end else begin
			mid_written_reg <= mid_written_reg | wr_mid_base;
			aux_written_reg <= aux_written_reg | wr_aux;
			aux_touched_reg <= aux_touched_reg | touch_aux;
			rdata_reg       <= rdata_next;
		end
	end

	// ------------------------------------------------------------
	// Mode of the high peripheral pins
	// ------------------------------------------------------------
	mrcs_hp_mode_t hp_mode;
	wire mid_en = mid_written_reg && aux_written_reg;

	// Chip-select use also needs the peripheral base; address use does not
	assign hp_mode = (sel_vs_addr_reg && aux_written_reg && periph_base_written) ? MRCS_HP_CS :
	                 (!sel_vs_addr_reg && aux_touched_reg) ? MRCS_HP_ADDR :
	                 MRCS_HP_OFF;

	// ------------------------------------------------------------
	// Decode and cycle sequencing
	// ------------------------------------------------------------
	logic       mid_hit;
	logic [1:0] mid_idx;
	logic [1:0] hp_hit;
	logic       seq_busy;
	logic       busy_reg;
	logic       launch_reg;
	logic [1:0] launch_ws_reg;
	logic       launch_ign_reg;
	logic       cyc_mem_reg;
	logic [3:0] mid_out_reg;
	logic [3:0] mid_out_next;
	logic [1:0] hp_out_reg;
	logic [1:0] hp_out_next;

	mrcs_decode u_decode (
		.addr         (cyc_addr),
		.cyc_mem      (cyc_mem),
		.mid_en       (mid_en),
		.mid_base     (mid_base_reg),
		.mid_size     (mid_size_reg),
		.hp_en        (hp_mode == MRCS_HP_CS),
		.hp_base      (periph_base_bits),
		.hp_space_mem (space_mem_reg),
		.mid_hit      (mid_hit),
		.mid_idx      (mid_idx),
		.hp_hit       (hp_hit)
	);

	// A start that arrives while a cycle is open is dropped
	wire take_start = cyc_start && !busy_reg;
	wire any_hp     = |hp_hit;

	// Unselected cycles finish on their own, with no waits
	wire [1:0] pick_ws  = mid_hit ? mid_ws_reg : any_hp ? hp_ws_reg : 2'h0;
	wire       pick_ign = mid_hit ? mid_rdy_reg : any_hp ? hp_rdy_reg : 1'b1;
	wire [3:0] mid_onehot_n = ~(4'h1 << mid_idx);

	mrcs_wait u_wait (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.start      (launch_reg),
		.ws_in      (launch_ws_reg),
		.rdy_ignore (launch_ign_reg),
		.ext_ready  (ext_ready),
		.busy       (seq_busy),
		.done       (cyc_done)
	);

	// Selects go low one clock after the address phase, with the muxed bus
	assign mid_out_next = !mid_en                ? 4'hf :
	                      (take_start && mid_hit) ? mid_onehot_n :
	                      cyc_done               ? 4'hf :
	                                               mid_out_reg;

	assign hp_out_next = (hp_mode == MRCS_HP_ADDR) ?
	                         (take_start ? {cyc_addr[2], cyc_addr[1]} : hp_out_reg) :
	                     (hp_mode == MRCS_HP_CS) ?
	                         // Idle pins go high, so latched address bits never linger as selects
	                         (take_start ? ~hp_hit :
	                          (cyc_done || !busy_reg) ? 2'b11 : hp_out_reg) :
	                         2'b11;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			busy_reg       <= 1'b0;
			launch_reg     <= 1'b0;
			launch_ws_reg  <= 2'h0;
			launch_ign_reg <= 1'b1;
			cyc_mem_reg    <= 1'b0;
		end else begin
			busy_reg       <= take_start | (busy_reg & ~cyc_done);
			launch_reg     <= take_start;
			launch_ws_reg  <= take_start ? pick_ws : launch_ws_reg;
			launch_ign_reg <= take_start ? pick_ign : launch_ign_reg;
			cyc_mem_reg    <= take_start ? cyc_mem : cyc_mem_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mid_out_reg <= 4'hf;
			hp_out_reg  <= 2'b11;
		end else begin
			mid_out_reg <= mid_out_next;
			hp_out_reg  <= hp_out_next;
		end
	end

	assign midrange_selects_n        = mid_out_reg;
	assign high_peripheral_selects_n = hp_out_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Remembers the expected select pattern for the timing check
	logic [3:0] mid_onehot_reg;
	always_ff @(posedge sys_clk) begin
		mid_onehot_reg <= mid_onehot_n;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_mid_held_off: assert property (
		!(mid_written_reg && aux_written_reg) |-> midrange_selects_n == 4'hf)
		else $error("midrange select active before both registers written");

	a_mid_late_assert: assert property (
		take_start && mid_hit |-> midrange_selects_n == 4'hf
			##1 midrange_selects_n == mid_onehot_reg)
		else $error("midrange select not asserted one clock after address phase");

	a_mid_single_sel: assert property (
		$onehot0(~midrange_selects_n))
		else $error("more than one midrange select active");

	a_hp_idle_high: assert property (
		hp_mode == MRCS_HP_OFF |=> high_peripheral_selects_n == 2'b11 || hp_mode != MRCS_HP_OFF)
		else $error("high peripheral pins not idle high");

	a_hp_addr_latch: assert property (
		hp_mode == MRCS_HP_ADDR && take_start |=>
			hp_mode != MRCS_HP_ADDR
			|| high_peripheral_selects_n == {$past(cyc_addr[2]), $past(cyc_addr[1])})
		else $error("latched address bits wrong on high peripheral pins");

	a_hp_addr_wakeup: assert property (
		!sel_vs_addr_reg && touch_aux |=> hp_mode == MRCS_HP_ADDR || sel_vs_addr_reg)
		else $error("auxiliary access did not activate address mode");

	a_hp_space_match: assert property (
		hp_mode == MRCS_HP_CS && high_peripheral_selects_n != 2'b11
			|-> cyc_mem_reg == space_mem_reg || $past(hp_mode) != MRCS_HP_CS)
		else $error("high peripheral select in wrong bus space");

	a_sel_release: assert property (
		cyc_done && mid_en |=> midrange_selects_n == 4'hf)
		else $error("midrange select not released after cycle end");

	c_mid_cycle:  cover property (take_start && mid_hit ##[1:8] cyc_done);
	c_hp_cs:      cover property (take_start && any_hp ##[1:8] cyc_done);
	c_hp_addr:    cover property (hp_mode == MRCS_HP_ADDR && take_start);
	c_ready_wait: cover property (seq_busy && !ext_ready ##1 seq_busy && ext_ready);
endmodule

`default_nettype wire

// ===== src/mrcs_wait.sv
/*
 Wait-state and ready sequencer for one selected bus cycle.
 Assumes start is a one-cycle pulse and never comes while busy.
*/
`timescale 1ns/1ps
`default_nettype none

module mrcs_wait
	import mrcs_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Cycle control
	input  wire logic       start,
	input  wire logic [1:0] ws_in,
	input  wire logic       rdy_ignore,
	input  wire logic       ext_ready,
	// Status
	output logic            busy,
	output logic            done
);
	mrcs_ws_state_t state_reg;
	mrcs_ws_state_t state_next;
	logic [1:0]     cnt_reg;
	logic [1:0]     cnt_next;
	logic           ign_reg;
	logic           ign_next;

	wire counting = (state_reg == MRCS_WS_COUNT);
	assign busy = counting;
	// Ready is looked at only after the programmed waits are spent
	assign done = counting && (cnt_reg == 2'h0) && (ign_reg || ext_ready);

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		ign_next   = ign_reg;
		case (state_reg)
			MRCS_WS_IDLE: begin
				if (start) begin
					state_next = MRCS_WS_COUNT;
					cnt_next   = ws_in;
					ign_next   = rdy_ignore;
				end
			end
			MRCS_WS_COUNT: begin
				if (done) begin
					state_next = MRCS_WS_IDLE;
				end else if (cnt_reg != 2'h0) begin
					cnt_next = cnt_reg - 2'h1;
				end
			end
			default: state_next = MRCS_WS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= MRCS_WS_IDLE;
			cnt_reg   <= 2'h0;
			ign_reg   <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			ign_reg   <= ign_next;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_ws_three_waits: assert property (
		start && !counting && ws_in == 2'h3 && rdy_ignore |=> !done [*3] ##1 done)
		else $error("three wait states not honoured");
	a_ready_holds: assert property (
		counting && !ign_reg && !ext_ready |=> state_reg == MRCS_WS_COUNT)
		else $error("cycle ended without external ready");
endmodule

`default_nettype wire

// ===== tb/midrange_peripheral_chip_select_test.sv
/*
 Self-checking bench for the chip-select unit against an integer model.
 Assumes the far-side model raises ready a set delay after a select.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mrcs_consts.svh"

module midrange_peripheral_chip_select_test;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        cyc_start = 1'b0;
	logic [19:0] cyc_addr = 20'h00000;
	logic        cyc_mem = 1'b0;
	logic [8:0]  pbase = 9'h000;
	logic        pbw = 1'b0;
	logic [2:0]  delay = 3'h0;
	logic [15:0] reg_rdata;
	logic        cyc_done;
	logic        ext_ready;
	logic        hp_cs;
	logic [3:0]  msel_n;
	logic [1:0]  hsel_n;
	int          mb_img, ax_img, mb_wr, ax_wr, touched;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          seed = 69357;
	int          cycles = 0;
	int          k, q, s, base;

	mrcs_top i_dut (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cyc_start(cyc_start), .cyc_addr(cyc_addr), .cyc_mem(cyc_mem),
		.ext_ready(ext_ready), .cyc_done(cyc_done),
		.periph_base_bits(pbase), .periph_base_written(pbw),
		.midrange_selects_n(msel_n), .high_peripheral_selects_n(hsel_n)
	);
	assign hp_cs = (ax_wr != 0) && ax_img[7] && pbw;
	mrcs_far_side i_far (
		.sys_clk(sys_clk), .midrange_selects_n(msel_n),
		.high_peripheral_selects_n(hsel_n), .hp_cs_mode(hp_cs),
		.delay(delay), .ext_ready(ext_ready)
	);

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		mb_img = 'h01f8;
		ax_img = 'h80f8;
		mb_wr = 0;
		ax_wr = 0;
		touched = 0;
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		if (a == `MRCS_OFS_MID_BASE) begin
			mb_img = (d & 'hfe07) | 'h01f8;
			mb_wr = 1;
		end
		if (a == `MRCS_OFS_AUX_CFG) begin
			ax_img = (d & 'h7fc7) | 'h8038;
			ax_wr = 1;
			touched = 1;
		end
	endtask

	task automatic reg_read(input logic [7:0] a);
		int exp;
		exp = 0;
		if (a == `MRCS_OFS_MID_BASE) exp = mb_img;
		if (a == `MRCS_OFS_AUX_CFG) begin
			exp = ax_img;
			touched = 1;
		end
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check("reg_rdata", exp[15:0], reg_rdata);
	endtask

	// One bus cycle, compared with the model on selects and length
	task automatic bus(input logic [19:0] a, input logic m);
		int sz, kk, ws, rdy, n, en, amode, slot;
		logic [3:0] em;
		logic [1:0] eh;
		sz = (ax_img >> 8) & 'h7f;
		em = 4'hf;
		eh = 2'h3;
		ws = 0;
		rdy = 1;
		amode = !ax_img[7] && touched;
		if (mb_wr && ax_wr && m && $countones(sz) == 1) begin
			kk = $clog2(sz);
			if ((a >> (13 + kk)) == (((mb_img >> 9) & 'h7f) >> kk)) begin
				em = ~(4'h1 << ((a >> (11 + kk)) & 3));
				ws = mb_img & 3;
				rdy = mb_img[2];
			end
		end
		slot = (a >> 8) & 7;
		if (hp_cs && (a >> 11) == pbase && m == ax_img[6] && (slot == 5 || slot == 6)) begin
			eh = (slot == 5) ? 2'h2 : 2'h1;
			ws = ax_img & 3;
			rdy = ax_img[2];
		end
		if (amode) eh = {a[2], a[1]};
		@(posedge sys_clk);
		// Launch cycle and first sequencer cycle plus the waits; delay is read once its update has landed
		en = 2 + ws;
		if (!rdy && delay + 1 > en) en = delay + 1;
		cyc_addr  <= a;
		cyc_mem   <= m;
		cyc_start <= 1'b1;
		#1;
		check("address phase selects", 4'hf, msel_n);
		@(posedge sys_clk);
		cyc_start <= 1'b0;
		#1;
		check("midrange_selects_n", em, msel_n);
		check("high_peripheral_selects_n", eh, hsel_n);
		n = 1;
		while (cyc_done !== 1'b1 && n < 30) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check("cycle length", en[15:0], n[15:0]);
		@(posedge sys_clk);
		#1;
		check("midrange after done", 4'hf, msel_n);
		check("high pins after done", eh | (amode ? 2'h0 : 2'h3), hsel_n);
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 6000) begin
			n_mismatch++;
			finish_test();
		end
	end

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	initial begin
		do_reset();
		#1;
		check("selects in reset", 4'hf, msel_n);
		check("high pins in reset", 2'h3, hsel_n);
		reg_read(`MRCS_OFS_MID_BASE);
		reg_read(`MRCS_OFS_AUX_CFG);
		reg_read(8'ha4);
		bus(20'h00000, 1'b1);
		reg_write(`MRCS_OFS_MID_BASE, 16'h01f8);
		bus(20'h00000, 1'b1);
		for (k = 0; k < 7; k++) begin
			base = (k == 6) ? 0 : (($random(seed) & 'h3f) & ~((1 << k) - 1));
			reg_write(`MRCS_OFS_MID_BASE, 16'(base << 9) | 16'h01f8 | 16'($random(seed) & 7));
			reg_write(`MRCS_OFS_AUX_CFG, 16'h80f8 | 16'((1 << k) << 8) | 16'($random(seed) & 7));
			reg_read(`MRCS_OFS_MID_BASE);
			reg_read(`MRCS_OFS_AUX_CFG);
			for (q = 0; q < 5; q++) begin
				delay <= 3'($random(seed));
				bus(20'((base << 13) + q * (2048 << k) + $unsigned($random(seed)) % (2048 << k)), 1'b1);
			end
			bus(20'(base << 13), 1'b0);
		end
		do_reset();
		pbase <= 9'h100 | 9'($random(seed));
		bus(20'($random(seed)), 1'b1);
		reg_write(`MRCS_OFS_AUX_CFG, 16'h8138);
		repeat (4) bus(20'($random(seed)), 1'($random(seed)));
		pbw <= 1'b1;
		for (s = 0; s < 2; s++) begin
			reg_write(`MRCS_OFS_AUX_CFG, 16'h80b8 | 16'(s << 6) | 16'($random(seed) & 7));
			for (q = 4; q < 8; q++) begin
				delay <= 3'($random(seed));
				bus({pbase, 3'(q), 8'($random(seed))}, 1'(s));
				bus({pbase, 3'(q), 8'h00}, 1'(~s));
			end
		end
		finish_test();
	end
endmodule
`default_nettype wire

// ===== tb/mrcs_far_side.sv
/*
 Far-side model: the memories and peripherals behind the select pins.
 Assumes the bench says whether the high pins are selects or address bits.
*/
`timescale 1ns/1ps
`default_nettype none

module mrcs_far_side (
	// Clock
	input  wire logic       sys_clk,
	// Pins seen from outside
	input  wire logic [3:0] midrange_selects_n,
	input  wire logic [1:0] high_peripheral_selects_n,
	input  wire logic       hp_cs_mode,
	// Answer delay in cycles after select
	input  wire logic [2:0] delay,
	output logic            ext_ready
);
	logic [3:0] cnt_reg = 4'h0;
	logic       idle_reg = 1'b0;
	wire logic  active;

	assign active = (midrange_selects_n != 4'hf) ||
		(hp_cs_mode && high_peripheral_selects_n != 2'h3);
	// Unselected, nobody drives ready: it wanders so a stale level never helps
	always_ff @(posedge sys_clk) begin
		cnt_reg  <= active ? cnt_reg + 4'h1 : 4'h0;
		idle_reg <= ~idle_reg;
	end
	assign ext_ready = active ? (cnt_reg >= {1'b0, delay}) : idle_reg;
endmodule
`default_nettype wire
